/* File: design/pok_pkg.sv */
// Register map, field layout and reset values of the power-ok block.
package pok_pkg;

    localparam logic [7:0] OFS_CTRL_ONE = 8'h15;
    localparam logic [7:0] OFS_CTRL_TWO = 8'h16;
    localparam logic [7:0] OFS_FAULT    = 8'h17;
    localparam logic [7:0] OFS_SWRST    = 8'h18;
    localparam logic [7:0] OFS_TOP      = 8'h19;
    localparam logic [7:0] OFS_TOP_TWO  = 8'h1A;

    localparam logic [7:0] RST_CTRL_ONE = 8'h73;
    localparam logic [2:0] RST_CTRL_TWO = 3'h4;
    localparam logic [3:0] RST_FAULT    = 4'h0;
    localparam logic [7:0] RST_TOP      = 8'h00;

    localparam int CT1_POL    = 7;
    localparam int CT2_TWARN  = 2;
    localparam int CT2_SRC    = 1;
    localparam int CT2_MODE   = 0;
    localparam int SWRST_BIT  = 0;
    localparam int RSTOCC_BIT = 0;

    localparam int TOP_POK   = 7;
    localparam int TOP_LDO   = 6;
    localparam int TOP_BUCK  = 5;
    localparam int TOP_CLK   = 4;
    localparam int TOP_TSD   = 3;
    localparam int TOP_TWARN = 2;
    localparam int TOP_OVP   = 1;
    localparam int TOP_MEAS  = 0;

    // Latched bits of the top flag register; summaries are excluded.
    localparam logic [7:0] TOP_W1C_MASK = 8'h9F;

    // Device address on the serial port; the value is arbitrary.
    localparam logic [6:0] DEV_ADDR = 7'h60;

    localparam logic [3:0] CNT_BYTE     = 4'h8;
    localparam logic [3:0] CNT_LAST_OUT = 4'h7;
    localparam logic [1:0] SETTLE_CYC   = 2'h3;

    typedef enum {
        ST_IDLE,
        ST_DEV,
        ST_DEV_ACK,
        ST_REG,
        ST_REG_ACK,
        ST_WDATA,
        ST_WDATA_ACK,
        ST_RDATA,
        ST_RDATA_ACK
    } ser_state_e;

endpackage

/* File: design/sync_two_ff.sv */
// Two-stage synchroniser for a bundle of independent level inputs.
`timescale 1ns/100ps
module sync_two_ff #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk_in,
    input  wire logic             nrst_in,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage_one_ff;
    logic [WIDTH-1:0] stage_two_ff;

    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            stage_one_ff <= '0;
            stage_two_ff <= '0;
        end else begin
            stage_one_ff <= async_in;
            stage_two_ff <= stage_one_ff;
        end
    end

    assign sync_out = stage_two_ff;

endmodule

/* File: design/power_ok_fault_interrupt_regs.sv */
// Power-ok qualification, fault latches, software reset and top flags.
`timescale 1ns/100ps
module power_ok_fault_interrupt_regs (
    input  wire logic       clk_in,
    input  wire logic       nrst_in,
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output logic            sda_out_out,
    output logic            sda_oe_out,
    input  wire logic [3:0] reg_valid_in,
    input  wire logic       live_thermal_warning_in,
    input  wire logic       live_thermal_shutdown_in,
    input  wire logic       live_overvoltage_in,
    input  wire logic       ext_clock_present_in,
    input  wire logic       meas_done_in,
    input  wire logic [7:0] ldo_interrupt_reg_in,
    input  wire logic [7:0] buck_interrupt_reg_in,
    input  wire logic [3:0] reg_enable_req_in,
    input  wire logic       general_output_a_req_in,
    input  wire logic       general_output_b_req_in,
    output logic            power_ok_output_out,
    output logic [3:0]      reg_enable_out,
    output logic            general_output_a_out,
    output logic            general_output_b_out,
    output logic            otp_reload_out
);

    // Synchronised pins and analog status levels.
    logic       scl_s;
    logic       sda_s;
    logic [3:0] valid_s;
    logic       twarn_s;
    logic       tsd_s;
    logic       ovp_s;
    logic       extclk_s;

    logic       scl_prev_ff;
    logic       sda_prev_ff;
    logic       extclk_prev_ff;
    logic [1:0] settle_ff;

    logic       soft_rst_ff;
    logic       rst_all;

    pok_pkg::ser_state_e state_ff;
    logic [3:0] cnt_ff;
    logic [7:0] shift_ff;
    logic [7:0] ptr_ff;
    logic       rw_ff;
    logic       mack_ff;
    logic       oe_ff;

    logic       scl_rise;
    logic       scl_fall;
    logic       start_cond;
    logic       stop_cond;
    logic       wr_stb;
    logic [7:0] rd_data;

    logic [7:0] ctrl_one_ff;
    logic [2:0] ctrl_two_ff;
    logic [3:0] fault_ff;
    logic [7:0] top_ff;
    logic       rst_occ_ff;
    logic [3:0] reg_en_ff;
    logic       gpo_a_ff;
    logic       gpo_b_ff;
    logic       pok_active_ff;
    logic       pok_pin_ff;

    logic [3:0] valid_eff;
    logic [3:0] live_bad;
    logic       pok_active;
    logic       fault_block;
    logic [3:0] nxt_fault;
    logic [7:0] nxt_top;
    logic [7:0] top_set;
    logic [7:0] top_clr;
    logic [3:0] fault_clr;
    logic       events_ok;

    sync_two_ff #(
        .WIDTH (10)
    ) u_sync (
        .clk_in   (clk_in),
        .nrst_in  (nrst_in),
        .async_in ({scl_in, sda_in, reg_valid_in,
                    live_thermal_warning_in, live_thermal_shutdown_in,
                    live_overvoltage_in, ext_clock_present_in}),
        .sync_out ({scl_s, sda_s, valid_s,
                    twarn_s, tsd_s, ovp_s, extclk_s})
    );

    // Software reset acts like the power-on reset on every register
    // except the synchronisers, the edge history and settle counter,
    // the reset command bit and the reset-occurred flag.
    assign rst_all = !nrst_in || soft_rst_ff;

    // Edge history and a short settle window so that filling the
    // synchronisers after reset is not mistaken for a clock event.
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            scl_prev_ff    <= 1'b0;
            sda_prev_ff    <= 1'b0;
            extclk_prev_ff <= 1'b0;
            settle_ff      <= pok_pkg::SETTLE_CYC;
        end else begin
            scl_prev_ff    <= scl_s;
            sda_prev_ff    <= sda_s;
            extclk_prev_ff <= extclk_s;
            if (settle_ff != 2'h0) begin
                settle_ff <= settle_ff - 2'h1;
            end
        end
    end

    assign events_ok  = (settle_ff == 2'h0);
    assign scl_rise   = events_ok && scl_s && !scl_prev_ff;
    assign scl_fall   = events_ok && !scl_s && scl_prev_ff;
    assign start_cond = events_ok && scl_s && scl_prev_ff
                        && sda_prev_ff && !sda_s;
    assign stop_cond  = events_ok && scl_s && scl_prev_ff
                        && !sda_prev_ff && sda_s;

    assign wr_stb = (state_ff == pok_pkg::ST_WDATA) && scl_fall
                    && (cnt_ff == pok_pkg::CNT_BYTE);

    // Serial slave: address byte, register pointer, then data bytes
    // with auto-increment. A software reset drops any transfer.
    always_ff @(posedge clk_in) begin
        if (rst_all) begin
            state_ff <= pok_pkg::ST_IDLE;
            cnt_ff   <= 4'h0;
            shift_ff <= 8'h00;
            ptr_ff   <= 8'h00;
            rw_ff    <= 1'b0;
            mack_ff  <= 1'b0;
            oe_ff    <= 1'b0;
        end else if (start_cond) begin
            state_ff <= pok_pkg::ST_DEV;
            cnt_ff   <= 4'h0;
            oe_ff    <= 1'b0;
        end else if (stop_cond) begin
            state_ff <= pok_pkg::ST_IDLE;
            oe_ff    <= 1'b0;
        end else begin
            unique case (state_ff)
                pok_pkg::ST_IDLE: begin
                    oe_ff <= 1'b0;
                end
                pok_pkg::ST_DEV, pok_pkg::ST_REG,
                pok_pkg::ST_WDATA: begin
                    if (scl_rise) begin
                        shift_ff <= {shift_ff[6:0], sda_s};
                        cnt_ff   <= cnt_ff + 4'h1;
                    end else if (scl_fall
                                 && cnt_ff == pok_pkg::CNT_BYTE) begin
                        if (state_ff == pok_pkg::ST_DEV) begin
                            if (shift_ff[7:1] == pok_pkg::DEV_ADDR) begin
                                rw_ff    <= shift_ff[0];
                                oe_ff    <= 1'b1;
                                state_ff <= pok_pkg::ST_DEV_ACK;
                            end else begin
                                state_ff <= pok_pkg::ST_IDLE;
                            end
                        end else if (state_ff == pok_pkg::ST_REG) begin
                            ptr_ff   <= shift_ff;
                            oe_ff    <= 1'b1;
                            state_ff <= pok_pkg::ST_REG_ACK;
                        end else begin
                            oe_ff    <= 1'b1;
                            state_ff <= pok_pkg::ST_WDATA_ACK;
                        end
                    end
                end
                pok_pkg::ST_DEV_ACK: begin
                    if (scl_fall) begin
                        cnt_ff <= 4'h0;
                        if (rw_ff) begin
                            shift_ff <= rd_data;
                            oe_ff    <= !rd_data[7];
                            state_ff <= pok_pkg::ST_RDATA;
                        end else begin
                            oe_ff    <= 1'b0;
                            state_ff <= pok_pkg::ST_REG;
                        end
                    end
                end
                pok_pkg::ST_REG_ACK, pok_pkg::ST_WDATA_ACK: begin
                    if (scl_fall) begin
                        if (state_ff == pok_pkg::ST_WDATA_ACK) begin
                            ptr_ff <= ptr_ff + 8'h01;
                        end
                        cnt_ff   <= 4'h0;
                        oe_ff    <= 1'b0;
                        state_ff <= pok_pkg::ST_WDATA;
                    end
                end
                pok_pkg::ST_RDATA: begin
                    if (scl_fall) begin
                        if (cnt_ff == pok_pkg::CNT_LAST_OUT) begin
                            oe_ff    <= 1'b0;
                            ptr_ff   <= ptr_ff + 8'h01;
                            state_ff <= pok_pkg::ST_RDATA_ACK;
                        end else begin
                            shift_ff <= {shift_ff[6:0], 1'b0};
                            oe_ff    <= !shift_ff[6];
                            cnt_ff   <= cnt_ff + 4'h1;
                        end
                    end
                end
                pok_pkg::ST_RDATA_ACK: begin
                    if (scl_rise) begin
                        mack_ff <= !sda_s;
                    end else if (scl_fall) begin
                        if (mack_ff) begin
                            cnt_ff   <= 4'h0;
                            shift_ff <= rd_data;
                            oe_ff    <= !rd_data[7];
                            state_ff <= pok_pkg::ST_RDATA;
                        end else begin
                            state_ff <= pok_pkg::ST_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    // Open-drain data line: only ever pulled low.
    assign sda_out_out = 1'b0;
    assign sda_oe_out  = oe_ff;

    // Read mux; the summary bits are live views of the regulator
    // interrupt registers, never stored here.
    always_comb begin
        rd_data = 8'h00;
        unique case (ptr_ff)
            pok_pkg::OFS_CTRL_ONE: rd_data = ctrl_one_ff;
            pok_pkg::OFS_CTRL_TWO: rd_data = {5'h00, ctrl_two_ff};
            pok_pkg::OFS_FAULT:    rd_data = {4'h0, fault_ff};
            pok_pkg::OFS_SWRST:    rd_data = {7'h00, soft_rst_ff};
            pok_pkg::OFS_TOP: begin
                rd_data = top_ff;
                rd_data[pok_pkg::TOP_LDO]  =
                    (ldo_interrupt_reg_in != 8'h00);
                rd_data[pok_pkg::TOP_BUCK] =
                    (buck_interrupt_reg_in != 8'h00);
            end
            pok_pkg::OFS_TOP_TWO:  rd_data = {7'h00, rst_occ_ff};
            default:               rd_data = 8'h00;
        endcase
    end

    // A one-cycle pulse performs the reset and then the bit reads back
    // as zero without any action from the host.
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            soft_rst_ff <= 1'b0;
        end else begin
            soft_rst_ff <= wr_stb && ptr_ff == pok_pkg::OFS_SWRST
                           && shift_ff[pok_pkg::SWRST_BIT];
        end
    end

    assign otp_reload_out = soft_rst_ff;

    // Reset-occurred survives the software reset it reports.
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            rst_occ_ff <= 1'b0;
        end else if (soft_rst_ff) begin
            rst_occ_ff <= 1'b1;
        end else if (wr_stb && ptr_ff == pok_pkg::OFS_TOP_TWO
                     && shift_ff[pok_pkg::RSTOCC_BIT]) begin
            rst_occ_ff <= 1'b0;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_all) begin
            ctrl_one_ff <= pok_pkg::RST_CTRL_ONE;
            ctrl_two_ff <= pok_pkg::RST_CTRL_TWO;
        end else if (wr_stb) begin
            if (ptr_ff == pok_pkg::OFS_CTRL_ONE) begin
                ctrl_one_ff <= shift_ff;
            end
            if (ptr_ff == pok_pkg::OFS_CTRL_TWO) begin
                ctrl_two_ff <= shift_ff[2:0];
            end
        end
    end

    // In gated mode a regulator that is switched off is not judged;
    // in continuous mode its output must be valid regardless.
    assign valid_eff = ctrl_two_ff[pok_pkg::CT2_MODE] ? valid_s
                       : (valid_s | ~reg_en_ff);
    assign live_bad  = ctrl_one_ff[3:0] & ~valid_eff;

    always_comb begin
        if (ctrl_two_ff[pok_pkg::CT2_SRC]) begin
            pok_active = (fault_ff == 4'h0);
        end else begin
            pok_active = (live_bad == 4'h0);
        end
        if (ctrl_two_ff[pok_pkg::CT2_TWARN] && twarn_s) begin
            pok_active = 1'b0;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_all) begin
            pok_active_ff <= 1'b0;
            pok_pin_ff    <= 1'b0;
        end else begin
            pok_active_ff <= pok_active;
            pok_pin_ff    <= pok_active
                             ^ ctrl_one_ff[pok_pkg::CT1_POL];
        end
    end

    assign power_ok_output_out = pok_pin_ff;

    // Set wins over a same-cycle clear; clear needs a valid output.
    assign fault_clr = (wr_stb && ptr_ff == pok_pkg::OFS_FAULT)
                       ? (shift_ff[3:0] & valid_s) : 4'h0;
    assign nxt_fault = (fault_ff & ~fault_clr) | live_bad;

    always_ff @(posedge clk_in) begin
        if (rst_all) begin
            fault_ff <= pok_pkg::RST_FAULT;
        end else begin
            fault_ff <= nxt_fault;
        end
    end

    always_comb begin
        top_set = 8'h00;
        top_set[pok_pkg::TOP_POK]   = pok_active_ff
                                      && !pok_active;
        top_set[pok_pkg::TOP_CLK]   = events_ok
                                      && (extclk_s
                                          != extclk_prev_ff);
        top_set[pok_pkg::TOP_TSD]   = tsd_s;
        top_set[pok_pkg::TOP_TWARN] = twarn_s;
        top_set[pok_pkg::TOP_OVP]   = ovp_s;
        top_set[pok_pkg::TOP_MEAS]  = meas_done_in;
    end

    // Summary bits are masked out so host writes to them do nothing.
    assign top_clr = (wr_stb && ptr_ff == pok_pkg::OFS_TOP)
                     ? (shift_ff & pok_pkg::TOP_W1C_MASK)
                     : 8'h00;
    assign nxt_top = ((top_ff & ~top_clr) | top_set)
                     & pok_pkg::TOP_W1C_MASK;

    always_ff @(posedge clk_in) begin
        if (rst_all) begin
            top_ff <= pok_pkg::RST_TOP;
        end else begin
            top_ff <= nxt_top;
        end
    end

    // The latched shutdown flag blocks enables even after the die has
    // cooled, so the host must acknowledge the event first.
    assign fault_block = top_ff[pok_pkg::TOP_TSD]
                         || tsd_s
                         || ovp_s;

    always_ff @(posedge clk_in) begin
        if (rst_all) begin
            reg_en_ff <= 4'h0;
            gpo_a_ff  <= 1'b0;
            gpo_b_ff  <= 1'b0;
        end else begin
            // Enables wait out the settle window: the valid synchronisers
            // still read zero then and would latch false faults.
            reg_en_ff <= (fault_block || !events_ok) ? 4'h0
                         : reg_enable_req_in;
            gpo_a_ff  <= general_output_a_req_in && !fault_block;
            gpo_b_ff  <= general_output_b_req_in && !fault_block;
        end
    end

    assign reg_enable_out       = reg_en_ff;
    assign general_output_a_out = gpo_a_ff;
    assign general_output_b_out = gpo_b_ff;

endmodule

/* File: tb/pok_regs_chk.sv */
// Port checker for the power-ok register block.
`timescale 1ns/100ps
module pok_regs_chk (
    input wire logic       clk_in,
    input wire logic       nrst_in,
    input wire logic       scl_in,
    input wire logic       sda_in,
    input wire logic       sda_oe_out,
    input wire logic [3:0] reg_valid_in,
    input wire logic       live_thermal_warning_in,
    input wire logic       live_thermal_shutdown_in,
    input wire logic       live_overvoltage_in,
    input wire logic [3:0] reg_enable_req_in,
    input wire logic       power_ok_output_out,
    input wire logic [3:0] reg_enable_out,
    input wire logic       general_output_a_out,
    input wire logic       general_output_b_out,
    input wire logic       otp_reload_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!nrst_in);

    chk_reset_quiet:
    assert property (disable iff (1'b0) !nrst_in |=> reg_enable_out == 4'h0
        && !power_ok_output_out && !sda_oe_out && !otp_reload_out)
        else $error("outputs active during reset");
    chk_tsd_kill:
    assert property (live_thermal_shutdown_in [*4] |=> reg_enable_out == 4'h0
        && !general_output_a_out && !general_output_b_out)
        else $error("outputs alive in thermal shutdown");
    chk_ovp_kill:
    assert property (live_overvoltage_in [*4] |=> reg_enable_out == 4'h0
        && !general_output_a_out && !general_output_b_out)
        else $error("outputs alive in overvoltage");
    chk_tsd_hold:
    assert property (live_thermal_shutdown_in [*4] ##1
        (!live_thermal_shutdown_in && !otp_reload_out)
        |=> (reg_enable_out == 4'h0) [*8])
        else $error("enable granted while shutdown flag set");
    chk_reload_single:
    assert property (otp_reload_out |=> !otp_reload_out [*8])
        else $error("reset command did not clear itself");
    chk_reload_serial:
    assert property (otp_reload_out |=> !sda_oe_out [*2])
        else $error("serial port not reset");
    chk_reload_scl_low:
    assert property (otp_reload_out |-> !scl_in)
        else $error("reset outside a written byte");
    chk_pok_steady:
    assert property ($stable({reg_valid_in, live_thermal_warning_in,
        live_thermal_shutdown_in, live_overvoltage_in, reg_enable_req_in,
        scl_in, sda_in}) [*8] |-> $stable(power_ok_output_out))
        else $error("power-ok moved with steady inputs");
endmodule

bind power_ok_fault_interrupt_regs pok_regs_chk pok_regs_chk_inst (
    .clk_in, .nrst_in, .scl_in, .sda_in, .sda_oe_out, .reg_valid_in,
    .live_thermal_warning_in, .live_thermal_shutdown_in,
    .live_overvoltage_in, .reg_enable_req_in, .power_ok_output_out,
    .reg_enable_out, .general_output_a_out, .general_output_b_out,
    .otp_reload_out);

/* File: tb/i2c_host_model.sv */
// Serial port host with an open-drain data line that is pulled up.
`timescale 1ns/100ps
module i2c_host_model (
    input  wire logic clk_in,
    input  wire logic sda_line_in,
    output logic      scl_out,
    output logic      sda_low_out
);
    // Ten clocks a half period stays clear of the eight-clock minimum.
    localparam int HALF = 10;

    initial begin
        scl_out = 1'b1;
        sda_low_out = 1'b0;
    end

    task automatic put(input logic c, input logic low);
        scl_out = c;
        sda_low_out = low;
        repeat (HALF) @(posedge clk_in);
        #1;
    endtask

    task automatic start_cond();
        put(1'b0, sda_low_out);
        put(1'b0, 1'b0);
        put(1'b1, 1'b0);
        put(1'b1, 1'b1);
        put(1'b0, 1'b1);
    endtask

    task automatic stop_cond();
        put(1'b0, sda_low_out);
        put(1'b0, 1'b1);
        put(1'b1, 1'b1);
        put(1'b1, 1'b0);
    endtask

    // Data moves only while the clock is low, so no false start or stop.
    task automatic clock_bit(input logic b, output logic r);
        put(1'b0, sda_low_out);
        put(1'b0, !b);
        put(1'b1, !b);
        r = sda_line_in;
    endtask

    task automatic byte_io(input logic [7:0] tx, input logic nine,
                           output logic [7:0] rx, output logic r9);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            clock_bit(tx[i], r);
            rx[i] = r;
        end
        clock_bit(nine, r9);
    endtask

    task automatic write_dev(input logic [6:0] dev, input logic [7:0] ptr,
                             input logic [7:0] d, output logic nack);
        logic [7:0] rx;
        logic       a;
        start_cond();
        byte_io({dev, 1'b0}, 1'b1, rx, nack);
        byte_io(ptr, 1'b1, rx, a);
        byte_io(d, 1'b1, rx, a);
        stop_cond();
    endtask

    task automatic read_reg(input logic [7:0] ptr, output logic [7:0] d);
        logic [7:0] rx;
        logic       a;
        start_cond();
        byte_io({pok_pkg::DEV_ADDR, 1'b0}, 1'b1, rx, a);
        byte_io(ptr, 1'b1, rx, a);
        start_cond();
        byte_io({pok_pkg::DEV_ADDR, 1'b1}, 1'b1, rx, a);
        // Released data bits and a final no-acknowledge end the read.
        byte_io(8'hFF, 1'b1, d, a);
        stop_cond();
    endtask
endmodule

/* File: tb/test_power_ok_fault_interrupt_regs.sv */
// Self-checking bench for the power-ok register block.
`timescale 1ns/100ps
module test_power_ok_fault_interrupt_regs;
    logic       clk_in = 1'b0;
    logic       nrst_in = 1'b0;
    logic [3:0] valid = 4'hF;
    logic [3:0] en_req = 4'hF;
    logic [7:0] ldo_irq = 8'h00;
    logic [7:0] buck_irq = 8'h00;
    logic       twarn = 1'b0, tsd = 1'b0, ovp = 1'b0;
    logic       xclk = 1'b0, meas = 1'b0;
    logic       scl, host_low, sda_oe, sda_line, pok, gpa, gpb, reload, ack;
    logic [3:0] en;
    logic [7:0] rdat;
    int         failures = 0;
    int         compares = 0;
    int         reloads = 0;

    always #2 clk_in = ~clk_in;
    assign sda_line = !(host_low || sda_oe);
    always @(posedge clk_in) begin
        if (reload === 1'b1) reloads <= reloads + 1;
    end

    power_ok_fault_interrupt_regs power_ok_fault_interrupt_regs_inst (
        .clk_in, .nrst_in, .scl_in(scl), .sda_in(sda_line),
        .sda_out_out(), .sda_oe_out(sda_oe), .reg_valid_in(valid),
        .live_thermal_warning_in(twarn), .live_thermal_shutdown_in(tsd),
        .live_overvoltage_in(ovp), .ext_clock_present_in(xclk),
        .meas_done_in(meas), .ldo_interrupt_reg_in(ldo_irq),
        .buck_interrupt_reg_in(buck_irq), .reg_enable_req_in(en_req),
        .general_output_a_req_in(1'b1), .general_output_b_req_in(1'b1),
        .power_ok_output_out(pok), .reg_enable_out(en),
        .general_output_a_out(gpa), .general_output_b_out(gpb),
        .otp_reload_out(reload));

    i2c_host_model i2c_host_model_inst (.clk_in, .sda_line_in(sda_line),
        .scl_out(scl), .sda_low_out(host_low));

    task automatic tick(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic pk(input logic e);
        check({7'h00, pok}, {7'h00, e});
    endtask

    task automatic wr(input logic [7:0] ptr, input logic [7:0] d);
        i2c_host_model_inst.write_dev(pok_pkg::DEV_ADDR, ptr, d, ack);
    endtask

    task automatic rd(input logic [7:0] ptr, input logic [7:0] exp);
        i2c_host_model_inst.read_reg(ptr, rdat);
        check(rdat, exp);
    endtask

    task automatic stop_test();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // About 46 transfers of under 1300 clocks each are expected.
    initial begin
        repeat (90000) @(posedge clk_in);
        failures++;
        stop_test();
    end

    initial begin
        tick(10);
        nrst_in = 1'b1;
        tick(5);
        rd(pok_pkg::OFS_CTRL_ONE, 8'h73);
        rd(pok_pkg::OFS_CTRL_TWO, 8'h04);
        rd(pok_pkg::OFS_FAULT, 8'h00);
        rd(pok_pkg::OFS_SWRST, 8'h00);
        rd(pok_pkg::OFS_TOP, 8'h00);
        rd(8'h20, 8'h00);
        pk(1'b1);
        twarn = 1'b1;
        tick(6);
        pk(1'b0);
        twarn = 1'b0;
        tick(6);
        pk(1'b1);
        rd(pok_pkg::OFS_TOP, 8'h84);
        wr(pok_pkg::OFS_TOP, 8'h00);
        rd(pok_pkg::OFS_TOP, 8'h84);
        wr(pok_pkg::OFS_TOP, 8'h84);
        rd(pok_pkg::OFS_TOP, 8'h00);
        wr(pok_pkg::OFS_CTRL_TWO, 8'hFF);
        rd(pok_pkg::OFS_CTRL_TWO, 8'h07);
        wr(pok_pkg::OFS_CTRL_TWO, 8'h00);
        twarn = 1'b1;
        tick(6);
        pk(1'b1);
        twarn = 1'b0;
        wr(pok_pkg::OFS_CTRL_ONE, 8'hFF);
        pk(1'b0);
        wr(pok_pkg::OFS_CTRL_ONE, 8'h0F);
        // A disabled regulator counts as good only in gated mode.
        en_req = 4'hB;
        valid = 4'hB;
        tick(6);
        pk(1'b1);
        wr(pok_pkg::OFS_CTRL_TWO, 8'h01);
        pk(1'b0);
        valid = 4'hF;
        en_req = 4'hF;
        tick(6);
        pk(1'b1);
        wr(pok_pkg::OFS_FAULT, 8'h04);
        rd(pok_pkg::OFS_FAULT, 8'h00);
        wr(pok_pkg::OFS_CTRL_TWO, 8'h03);
        valid = 4'hB;
        tick(6);
        valid = 4'hF;
        tick(6);
        pk(1'b0);
        rd(pok_pkg::OFS_FAULT, 8'h04);
        // Deselect the failing regulator so that only the valid gate
        // can keep its fault bit against the clear.
        valid = 4'hB;
        wr(pok_pkg::OFS_CTRL_ONE, 8'h0B);
        wr(pok_pkg::OFS_FAULT, 8'h04);
        rd(pok_pkg::OFS_FAULT, 8'h04);
        valid = 4'hF;
        wr(pok_pkg::OFS_FAULT, 8'h04);
        rd(pok_pkg::OFS_FAULT, 8'h00);
        pk(1'b1);
        rd(pok_pkg::OFS_TOP, 8'h84);
        wr(pok_pkg::OFS_TOP, 8'hFF);
        wr(pok_pkg::OFS_CTRL_TWO, 8'h00);
        ldo_irq = 8'h40;
        buck_irq = 8'h01;
        xclk = 1'b1;
        meas = 1'b1;
        tick(1);
        meas = 1'b0;
        rd(pok_pkg::OFS_TOP, 8'h71);
        wr(pok_pkg::OFS_TOP, 8'hFF);
        rd(pok_pkg::OFS_TOP, 8'h60);
        ldo_irq = 8'h00;
        buck_irq = 8'h00;
        xclk = 1'b0;
        rd(pok_pkg::OFS_TOP, 8'h10);
        wr(pok_pkg::OFS_TOP, 8'h10);
        ovp = 1'b1;
        tick(6);
        check({2'b00, gpa, gpb, en}, 8'h00);
        ovp = 1'b0;
        tick(6);
        check({2'b00, gpa, gpb, en}, 8'h3F);
        tsd = 1'b1;
        tick(6);
        tsd = 1'b0;
        rd(pok_pkg::OFS_TOP, 8'h0A);
        check({4'h0, en}, 8'h00);
        wr(pok_pkg::OFS_TOP, 8'h0A);
        check({2'b00, gpa, gpb, en}, 8'h3F);
        wr(pok_pkg::OFS_SWRST, 8'h01);
        rd(pok_pkg::OFS_CTRL_ONE, 8'h73);
        rd(pok_pkg::OFS_SWRST, 8'h00);
        check(8'(reloads), 8'h01);
        rd(pok_pkg::OFS_TOP_TWO, 8'h01);
        wr(pok_pkg::OFS_TOP_TWO, 8'h00);
        rd(pok_pkg::OFS_TOP_TWO, 8'h01);
        wr(pok_pkg::OFS_TOP_TWO, 8'h01);
        rd(pok_pkg::OFS_TOP_TWO, 8'h00);
        i2c_host_model_inst.write_dev(7'h61, 8'h16, 8'h00, ack);
        check({7'h00, ack}, 8'h01);
        rd(pok_pkg::OFS_CTRL_TWO, 8'h04);
        stop_test();
    end
endmodule
